// ==== logic/pwc_pkg.sv ====
// Package with constants, states and register layout of the power on/off controller.
package pwc_pkg;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PWC_SHUTDOWN = 3'h0,
        PWC_STANDBY  = 3'h1,
        PWC_RSRC_ON  = 3'h2,
        PWC_PU_SEQ   = 3'h3,
        PWC_PD_SEQ   = 3'h4,
        PWC_RST_ACT  = 3'h5,
        PWC_OFF_ACT  = 3'h6,
        PWC_SHIP     = 3'h7
    } pwc_state_e;

    // ------------------------------------------------------------
    // Soft power command codes and charger detail
    // ------------------------------------------------------------
    localparam logic [1:0] PWC_CMD_NONE = 2'h0;
    localparam logic [1:0] PWC_CMD_COLD = 2'h1;
    localparam logic [1:0] PWC_CMD_OFF  = 2'h2;
    localparam logic [1:0] PWC_CMD_SHIP = 2'h3;
    localparam logic [1:0] PWC_CHG_OK   = 2'h3;
    localparam logic [3:0] PWC_MUX_OFF  = 4'h0;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    localparam int PWC_SYNC_W = 4;
    localparam logic [PWC_SYNC_W-1:0] PWC_SYNC_RST = 4'h1;
    localparam int PWC_NRES = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] PWC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0] PWC_ADDR_STATUS = 8'h04;
    localparam int PWC_CTRL_CMD_LSB  = 0;
    localparam int PWC_CTRL_BIAS     = 2;
    localparam int PWC_CTRL_WDSEL    = 3;
    localparam int PWC_CTRL_MUX_LSB  = 4;
    localparam int PWC_CTRL_FEN_LSB  = 8;
    localparam int PWC_CTRL_FDIS_LSB = 12;
    localparam int PWC_ST_STATE_LSB  = 0;
    localparam int PWC_ST_PU_DONE    = 3;
    localparam int PWC_ST_WAKE       = 4;
    localparam int PWC_ST_WD_RST     = 5;
    localparam int PWC_ST_WD_OFF     = 6;
    localparam int PWC_ST_MR         = 7;
    localparam logic [31:0] PWC_CTRL_RST = 32'h0000_0000;

endpackage

// ==== logic/pwc_sync.sv ====
// Three-stage pin synchroniser with agreement filter on the last two stages.
`timescale 1ns/1ps
`default_nettype none

module pwc_sync (
    // Clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // Asynchronous pins in, filtered levels out
    input  wire logic [pwc_pkg::PWC_SYNC_W-1:0] pin_in,
    output logic      [pwc_pkg::PWC_SYNC_W-1:0] pin_out
);

    // ------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < pwc_pkg::PWC_SYNC_W; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            // The first stage feeds only the second; a level counts once stages two and three agree.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1         <= pwc_pkg::PWC_SYNC_RST[i];
                    s2         <= pwc_pkg::PWC_SYNC_RST[i];
                    s3         <= pwc_pkg::PWC_SYNC_RST[i];
                    pin_out[i] <= pwc_pkg::PWC_SYNC_RST[i];
                end else begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        pin_out[i] <= s3;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ==== logic/pwc_ctrl.sv ====
// Top-level power on/off state controller with APB register access.
//
// Notes on behaviour
// - Cold-reset command or watchdog expiry with select one enters reset actions.
// - Off command, watchdog off, lockouts or manual reset enter off actions.
// - Charger valid, enable asserted, or power-on reset leave low-power states.
// - Factory-ship command enters ship mode only while enable is not asserted.
// - Standby falls to shutdown without bias need, or on any down event.
// - Bias is needed when software requests it or wake conditions hold.
// - Any lockout takes resource-on straight back to standby.
// - Resource-on drops to standby without wake conditions or on down events before power-up.
// - Wake condition: monitor select, charger valid, forced resource, wake flag.
// - Sequencer power-up starts once, needs wake flag and not all resources forced off.
// - Sequencer power-up done returns to resource-on.
// - Sequencer power-down starts after power-up on force-off or down events.
// - Power-down path ends only when the sequencer reports completion.
// - Wake flags survive a reset-caused shutdown so the device powers again.
// - Wake flags set on enable edge, charger valid edge or cold-reset command.
// - A wake event reaches resource-on through standby.
// - Manual reset goes resource-on, power-down, standby, shutdown, off actions, then shutdown.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module pwc_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and comparators
    input  wire logic        enable_input_n,
    input  wire logic        overtemp_lockout,
    input  wire logic        rail_undervoltage,
    input  wire logic        rail_overvoltage,
    // Same-clock event sources
    input  wire logic [1:0]  charger_input_detail,
    input  wire logic        wdog_expired,
    input  wire logic        manual_reset,
    input  wire logic        seq_pu_done,
    input  wire logic        seq_pd_done,
    input  wire logic        action_done,
    // Controller outputs
    output logic [2:0]       state_code,
    output logic             seq_pu_start,
    output logic             seq_pd_start,
    output logic             reset_act_start,
    output logic             off_act_start,
    output logic             main_bias_on,
    output logic             factory_ship_on
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pwc_pkg::pwc_state_e state;
    pwc_pkg::pwc_state_e next_state;
    logic [pwc_pkg::PWC_SYNC_W-1:0] pins_s;
    logic [1:0] soft_power_command;
    logic       main_bias_request;
    logic       wdog_action_select;
    logic [3:0] analog_monitor_select;
    logic [pwc_pkg::PWC_NRES-1:0] force_en;
    logic [pwc_pkg::PWC_NRES-1:0] force_dis;
    logic wake_flag;
    logic pu_done;
    logic wdog_reset_flag;
    logic wdog_poweroff_flag;
    logic manual_reset_flag;
    logic wd_rst_pend;
    logic wd_off_pend;
    logic mr_pend;
    logic en_prev;
    logic chg_prev;
    logic en_on;
    logic chg_ok;
    logic lock;
    logic t6;
    logic t4;
    logic t0a;
    logic t0c;
    logic down_ev;
    logic all_dis;
    logic consume;
    logic wake_set;
    logic wr_ctrl;
    logic wr_stat;
    logic cold_wr;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pwc_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({rail_overvoltage, rail_undervoltage, overtemp_lockout, enable_input_n}),
        .pin_out (pins_s)
    );

    // ------------------------------------------------------------
    // Transition conditions
    // ------------------------------------------------------------
    // Every condition is a plain level on pclk so the state machine sees one snapshot.
    assign en_on   = ~pins_s[0];
    assign lock    = |pins_s[3:1];
    assign chg_ok  = (charger_input_detail == pwc_pkg::PWC_CHG_OK);
    assign all_dis = &force_dis;
    assign t6      = (analog_monitor_select != pwc_pkg::PWC_MUX_OFF) | chg_ok
                   | (|force_en) | wake_flag;
    assign t4      = main_bias_request | t6;
    assign down_ev = (soft_power_command != pwc_pkg::PWC_CMD_NONE)
                   | wd_rst_pend | wd_off_pend | mr_pend;
    assign t0a     = (soft_power_command == pwc_pkg::PWC_CMD_COLD) | wd_rst_pend;
    assign t0c     = (soft_power_command == pwc_pkg::PWC_CMD_OFF) | wd_off_pend
                   | lock | mr_pend;
    assign wr_ctrl = psel & penable & pwrite & pready & (paddr == pwc_pkg::PWC_ADDR_CTRL);
    assign wr_stat = psel & penable & pwrite & pready & (paddr == pwc_pkg::PWC_ADDR_STATUS);
    assign cold_wr = wr_ctrl & (pwdata[1:0] == pwc_pkg::PWC_CMD_COLD);
    assign wake_set = (en_on & ~en_prev) | (chg_ok & ~chg_prev) | cold_wr;

    // ------------------------------------------------------------
    // Next-state decode
    // ------------------------------------------------------------
    // Lockouts are checked first in shutdown, standby and resource-on so no command can mask them there.
    always_comb begin
        next_state = state;
        unique case (state)
            pwc_pkg::PWC_SHUTDOWN: begin
                if (t0c) begin
                    next_state = pwc_pkg::PWC_OFF_ACT;
                end else if (t0a) begin
                    next_state = pwc_pkg::PWC_RST_ACT;
                end else if ((soft_power_command == pwc_pkg::PWC_CMD_SHIP) && !en_on) begin
                    next_state = pwc_pkg::PWC_SHIP;
                end else if (t4) begin
                    next_state = pwc_pkg::PWC_STANDBY;
                end
            end
            pwc_pkg::PWC_STANDBY: begin
                if (lock) begin
                    next_state = pwc_pkg::PWC_OFF_ACT;
                end else if (!t4 || down_ev) begin
                    next_state = pwc_pkg::PWC_SHUTDOWN;
                end else if (t6) begin
                    next_state = pwc_pkg::PWC_RSRC_ON;
                end
            end
            pwc_pkg::PWC_RSRC_ON: begin
                if (lock) begin
                    next_state = pwc_pkg::PWC_STANDBY;
                end else if (pu_done && (all_dis || down_ev)) begin
                    next_state = pwc_pkg::PWC_PD_SEQ;
                end else if (!t6 || down_ev) begin
                    next_state = pwc_pkg::PWC_STANDBY;
                end else if (!pu_done && !all_dis && wake_flag) begin
                    next_state = pwc_pkg::PWC_PU_SEQ;
                end
            end
            pwc_pkg::PWC_PU_SEQ: begin
                if (seq_pu_done) begin
                    next_state = pwc_pkg::PWC_RSRC_ON;
                end
            end
            pwc_pkg::PWC_PD_SEQ: begin
                if (seq_pd_done) begin
                    next_state = pwc_pkg::PWC_STANDBY;
                end
            end
            pwc_pkg::PWC_RST_ACT, pwc_pkg::PWC_OFF_ACT: begin
                if (action_done) begin
                    next_state = pwc_pkg::PWC_SHUTDOWN;
                end
            end
            pwc_pkg::PWC_SHIP: begin
                if ((chg_ok && !chg_prev) || en_on) begin
                    next_state = pwc_pkg::PWC_SHUTDOWN;
                end
            end
        endcase
    end

    // A command leaves shutdown once acted on; a refused ship request is dropped too.
    assign consume = (state == pwc_pkg::PWC_SHUTDOWN)
                   && ((next_state != pwc_pkg::PWC_SHUTDOWN)
                   || ((soft_power_command == pwc_pkg::PWC_CMD_SHIP) && en_on));

    // ------------------------------------------------------------
    // State register and registered outputs
    // ------------------------------------------------------------
    // Power-on reset lands in shutdown, which is the battery re-apply exit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= pwc_pkg::PWC_SHUTDOWN;
            state_code      <= 3'h0;
            seq_pu_start    <= 1'b0;
            seq_pd_start    <= 1'b0;
            reset_act_start <= 1'b0;
            off_act_start   <= 1'b0;
            main_bias_on    <= 1'b0;
            factory_ship_on <= 1'b0;
        end else begin
            state           <= next_state;
            state_code      <= next_state;
            seq_pu_start    <= (next_state == pwc_pkg::PWC_PU_SEQ);
            seq_pd_start    <= (next_state == pwc_pkg::PWC_PD_SEQ);
            reset_act_start <= (next_state == pwc_pkg::PWC_RST_ACT);
            off_act_start   <= (next_state == pwc_pkg::PWC_OFF_ACT);
            main_bias_on    <= (next_state != pwc_pkg::PWC_SHUTDOWN)
                            && (next_state != pwc_pkg::PWC_SHIP);
            factory_ship_on <= (next_state == pwc_pkg::PWC_SHIP);
        end
    end

    // ------------------------------------------------------------
    // Edge history, power-up memory and wake flag
    // ------------------------------------------------------------
    // The wake flag is not cleared by reset actions; only a finished power-up clears it.
    // Shutdown forgets the power-up, as every resource is off there and must sequence again.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev   <= 1'b0;
            chg_prev  <= 1'b0;
            pu_done   <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            en_prev  <= en_on;
            chg_prev <= chg_ok;
            if (state == pwc_pkg::PWC_PU_SEQ && seq_pu_done) begin
                pu_done <= 1'b1;
            end else if ((state == pwc_pkg::PWC_PD_SEQ && seq_pd_done)
                         || state == pwc_pkg::PWC_SHUTDOWN) begin
                pu_done <= 1'b0;
            end
            if (wake_set) begin
                wake_flag <= 1'b1;
            end else if (state == pwc_pkg::PWC_PU_SEQ && seq_pu_done) begin
                wake_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Event cause flags and pending events
    // ------------------------------------------------------------
    // Flags are write-one-to-clear; a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_reset_flag    <= 1'b0;
            wdog_poweroff_flag <= 1'b0;
            manual_reset_flag  <= 1'b0;
            wd_rst_pend        <= 1'b0;
            wd_off_pend        <= 1'b0;
            mr_pend            <= 1'b0;
        end else begin
            if (wdog_expired && wdog_action_select) begin
                wdog_reset_flag <= 1'b1;
            end else if (wr_stat && pwdata[pwc_pkg::PWC_ST_WD_RST]) begin
                wdog_reset_flag <= 1'b0;
            end
            if (wdog_expired && !wdog_action_select) begin
                wdog_poweroff_flag <= 1'b1;
            end else if (wr_stat && pwdata[pwc_pkg::PWC_ST_WD_OFF]) begin
                wdog_poweroff_flag <= 1'b0;
            end
            if (manual_reset) begin
                manual_reset_flag <= 1'b1;
            end else if (wr_stat && pwdata[pwc_pkg::PWC_ST_MR]) begin
                manual_reset_flag <= 1'b0;
            end
            if (wdog_expired && wdog_action_select) begin
                wd_rst_pend <= 1'b1;
            end else if (consume) begin
                wd_rst_pend <= 1'b0;
            end
            if (wdog_expired && !wdog_action_select) begin
                wd_off_pend <= 1'b1;
            end else if (consume) begin
                wd_off_pend <= 1'b0;
            end
            if (manual_reset) begin
                mr_pend <= 1'b1;
            end else if (consume) begin
                mr_pend <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // A software write to the command field beats the hardware clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_power_command    <= pwc_pkg::PWC_CTRL_RST[1:0];
            main_bias_request     <= pwc_pkg::PWC_CTRL_RST[pwc_pkg::PWC_CTRL_BIAS];
            wdog_action_select    <= pwc_pkg::PWC_CTRL_RST[pwc_pkg::PWC_CTRL_WDSEL];
            analog_monitor_select <= pwc_pkg::PWC_CTRL_RST[7:4];
            force_en              <= pwc_pkg::PWC_CTRL_RST[11:8];
            force_dis             <= pwc_pkg::PWC_CTRL_RST[15:12];
        end else if (wr_ctrl) begin
            soft_power_command    <= pwdata[pwc_pkg::PWC_CTRL_CMD_LSB +: 2];
            main_bias_request     <= pwdata[pwc_pkg::PWC_CTRL_BIAS];
            wdog_action_select    <= pwdata[pwc_pkg::PWC_CTRL_WDSEL];
            analog_monitor_select <= pwdata[pwc_pkg::PWC_CTRL_MUX_LSB +: 4];
            force_en              <= pwdata[pwc_pkg::PWC_CTRL_FEN_LSB +: pwc_pkg::PWC_NRES];
            force_dis             <= pwdata[pwc_pkg::PWC_CTRL_FDIS_LSB +: pwc_pkg::PWC_NRES];
        end else if (consume) begin
            soft_power_command <= pwc_pkg::PWC_CMD_NONE;
        end
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // One wait state keeps pready and prdata straight from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                prdata <= 32'h0000_0000;
                if (paddr == pwc_pkg::PWC_ADDR_CTRL) begin
                    prdata[15:0] <= {force_dis, force_en, analog_monitor_select,
                                     wdog_action_select, main_bias_request,
                                     soft_power_command};
                end else if (paddr == pwc_pkg::PWC_ADDR_STATUS) begin
                    prdata[7:0] <= {manual_reset_flag, wdog_poweroff_flag,
                                    wdog_reset_flag, wake_flag, pu_done, state};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ship_entry: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_SHIP && $past(state) != pwc_pkg::PWC_SHIP |->
        $past(soft_power_command) == pwc_pkg::PWC_CMD_SHIP && !$past(en_on))
        else $error("ship mode entered without its command");
    chk_cold_reset: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_SHUTDOWN && soft_power_command == pwc_pkg::PWC_CMD_COLD
        && !t0c |=> state == pwc_pkg::PWC_RST_ACT ##0 reset_act_start)
        else $error("cold reset not taken");
    chk_lock_first: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_RSRC_ON && lock |=> state == pwc_pkg::PWC_STANDBY)
        else $error("lockout did not leave resource-on");
    chk_pu_done: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_PU_SEQ && seq_pu_done |=>
        state == pwc_pkg::PWC_RSRC_ON && pu_done && !seq_pu_start)
        else $error("power-up completion not followed");
    chk_pd_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_PD_SEQ && !seq_pd_done |=> state == pwc_pkg::PWC_PD_SEQ)
        else $error("power-down left early");
    chk_act_done: assert property (@(posedge pclk) disable iff (!presetn)
        (state == pwc_pkg::PWC_RST_ACT || state == pwc_pkg::PWC_OFF_ACT) ##1
        state == pwc_pkg::PWC_SHUTDOWN |-> $past(action_done))
        else $error("action left without done");
    chk_wake_set: assert property (@(posedge pclk) disable iff (!presetn)
        cold_wr |=> wake_flag)
        else $error("cold reset did not set wake flag");
    chk_pu_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(seq_pu_start) |-> !$past(pu_done) && $past(wake_flag) && !$past(all_dis))
        else $error("power-up started without cause");
    chk_standby_down: assert property (@(posedge pclk) disable iff (!presetn)
        state == pwc_pkg::PWC_STANDBY && !lock && !t4 |=> state == pwc_pkg::PWC_SHUTDOWN)
        else $error("standby did not fall to shutdown");

endmodule

`default_nettype wire

// ==== tb/pwc_seq_model.sv ====
// Behavioural model of the power sequencer and the action sequencers.
`timescale 1ns/1ps
`default_nettype none
module pwc_seq_model #(parameter int DLY = 3) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Start levels in (up, down, reset, off), done pulses out (up, down, action)
    input  wire logic [3:0] start,
    output logic      [2:0] done
);
    int cnt;
    // Each start is answered after DLY+1 cycles; a slower sequencer only needs a larger DLY.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            done <= 3'h0;
        end else begin
            cnt <= (|start && cnt != DLY) ? cnt + 1 : 0;
            done[0] <= start[0] && cnt == DLY;
            done[1] <= start[1] && cnt == DLY;
            done[2] <= |start[3:2] && cnt == DLY;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_pwc_ctrl.sv ====
// Self-checking bench of the power on/off controller.
`timescale 1ns/1ps
`default_nettype none
module tb_pwc_ctrl;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err, bias, ship, en_n = 1'b1, ot = 1'b0, wd = 1'b0, mr = 1'b0;
    logic uv = 1'b0, ov = 1'b0;
    logic [1:0] chg = 2'h0;
    logic [2:0] st, done;
    logic [3:0] start;
    int miscompares = 0, n_checks = 0;
    // Row: flags (write, watchdog pulse, lockout), control word, state to reach.
    logic [21:0] rows [10] = '{{3'h4, 16'h4, 3'h1}, {3'h4, 16'h0, 3'h0}, {3'h4, 16'h10, 3'h2},
        {3'h1, 16'h0, 3'h1}, {3'h4, 16'h0, 3'h0}, {3'h4, 16'h1, 3'h5}, {3'h0, 16'h0, 3'h3},
        {3'h4, 16'h8, 3'h0}, {3'h2, 16'h8, 3'h5}, {3'h6, 16'h2, 3'h6}};
    always #20 pclk = ~pclk;
    pwc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enable_input_n(en_n), .overtemp_lockout(ot),
        .rail_undervoltage(uv), .rail_overvoltage(ov), .charger_input_detail(chg),
        .wdog_expired(wd), .manual_reset(mr), .seq_pu_done(done[0]), .seq_pd_done(done[1]),
        .action_done(done[2]), .state_code(st), .seq_pu_start(start[0]),
        .seq_pd_start(start[1]), .reset_act_start(start[2]), .off_act_start(start[3]),
        .main_bias_on(bias), .factory_ship_on(ship));
    pwc_seq_model seq_u (.pclk(pclk), .presetn(presetn), .start(start), .done(done));
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    // One APB transfer; the request is held until pready is seen at an edge.
    // One idle edge follows, so back-to-back calls never rewrite psel in one time step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            chk(0, "bus hang");
            end_sim();
        end
        @(posedge pclk);
    endtask
    // Bounded wait for a state; running out counts as a mismatch.
    task automatic wait_st(input logic [2:0] e);
        for (int i = 0; i < 400 && st !== e; i++) @(posedge pclk);
        chk(st === e, "state not reached");
        if (st !== e) end_sim();
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(st === 3'h0 && bias === 1'b0 && start === 4'h0, "reset outputs");
        apb(1'b0, 8'h08, 32'h0);
        chk(err === 1'b1 && q === 32'h0, "unmapped read");
        foreach (rows[k]) begin
            ot <= rows[k][19];
            if (rows[k][21]) begin
                apb(1'b1, pwc_pkg::PWC_ADDR_CTRL, {16'h0, rows[k][18:3]});
            end
            if (rows[k][20]) begin
                wd <= 1'b1;
                @(posedge pclk);
                wd <= 1'b0;
            end
            wait_st(rows[k][2:0]);
            $display("row %0d done", k);
        end
        ot <= 1'b0;
        wait_st(3'h0);
        // Monitor select stays on so resource-on holds after the wake flag clears.
        apb(1'b1, pwc_pkg::PWC_ADDR_CTRL, 32'h13);
        wait_st(3'h7);
        chk(ship === 1'b1 && bias === 1'b0, "ship outputs");
        apb(1'b0, pwc_pkg::PWC_ADDR_STATUS, 32'h0);
        chk(q === 32'h67 && err === 1'b0, "status read");
        apb(1'b1, pwc_pkg::PWC_ADDR_STATUS, 32'h20);
        apb(1'b0, pwc_pkg::PWC_ADDR_STATUS, 32'h0);
        chk(q === 32'h47, "flag clear");
        en_n <= 1'b0;
        wait_st(3'h3);
        chk(start === 4'h1 && bias === 1'b1, "power-up outputs");
        wait_st(3'h2);
        en_n <= 1'b1;
        mr <= 1'b1;
        @(posedge pclk);
        mr <= 1'b0;
        wait_st(3'h4);
        wait_st(3'h1);
        wait_st(3'h6);
        wait_st(3'h0);
        $display("ship and manual reset test done");
        chg <= 2'h3;
        wait_st(3'h3);
        wait_st(3'h2);
        uv <= 1'b1;
        wait_st(3'h1);
        uv <= 1'b0;
        ov <= 1'b1;
        wait_st(3'h6);
        ov <= 1'b0;
        wait_st(3'h0);
        $display("charger and lockout test done");
        end_sim();
    end
endmodule
`default_nettype wire
